// ==== design/pot_serial_slave_interface.v ====
// Purpose: Two-wire serial slave of a quad digital potentiometer
// Assumes: scl and sda are asynchronous pins, sampled by core_clk
// Notes: Stored settings live in an internal array standing in for the non-volatile cells
// Function
// - Start is data falling while clock high
// - Stop is data rising while clock high
// - Ignore bus until a start is seen
// - Data change during clock high means start/stop
// - Upper nibble type code, lower nibble pins
// - Acknowledge address only on a match
// - Receiver pulls data low in ninth clock
// - Acknowledge every byte of a selected write, except the data byte of a protected stored write
// - Read: eight bits, sample ack, continue or wait
// - Write is address, instruction, data, then stop
// - Stored write programs at stop, bus ignored
// - Program cycle up to 5 ms, line released
// - Polling address acked only after programming
// - Protect low: no stored-write data ack, no programming
// - Protect falling before cycle aborts the write
// - Protect falling during cycle has no effect
// - Wiper settles 5 to 10 us after change
// - Power-up loads wiper from first stored setting
// - Register-select picks stored, low bits pick pot
`timescale 1ns/10ps
`include "pot_serial_map.vh"
module pot_serial_slave_interface #(
  parameter PROGRAM_CYCLES = `NV_PROGRAM_CYCLES,
  parameter SETTLE_CYCLES = `WIPER_SETTLE_CYCLES
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Two-wire bus pins
  input wire scl,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe,
  // Address select pins and write protect (active low)
  input wire addr_select_bit0,
  input wire addr_select_bit1,
  input wire addr_select_bit2,
  input wire addr_select_bit3,
  input wire writeProtect_n,
  // Wiper setting outputs, four pots of eight bits; settle and program-busy flags
  output reg [31:0] wiperSettings,
  output reg wiperSettled,
  output reg programBusy
);

  // ==========================================================
  // State codes
  localparam ST_IDLE = 3'h0;
  localparam ST_RECV = 3'h1;
  localparam ST_ACK = 3'h2;
  localparam ST_SEND = 3'h3;
  localparam ST_MACK = 3'h4;
  localparam ST_WAIT = 3'h5;
  localparam ST_LOAD = 3'h6;

  // Byte position within a transaction
  localparam BY_ADDR = 2'h0;
  localparam BY_INSTR = 2'h1;
  localparam BY_DATA = 2'h2;

  // ==========================================================
  // Pin synchronisers; first stage read only by second
  reg [1:0] sclSync;
  reg [1:0] sdaSync;
  reg [1:0] wpSync;
  reg sclPrev;
  reg sdaPrev;
  reg wpPrev;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      wpSync <= 2'h3;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      wpPrev <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], scl};
      sdaSync <= {sdaSync[0], sdaIn};
      wpSync <= {wpSync[0], writeProtect_n};
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
      wpPrev <= wpSync[1];
    end
  end

  wire sclNow = sclSync[1];
  wire sdaNow = sdaSync[1];
  wire wpNow = wpSync[1];
  wire sclRise = sclNow & ~sclPrev;
  wire sclFall = ~sclNow & sclPrev;
  // Data edges with clock high are conditions, never data
  wire startSeen = sclNow & sclPrev & sdaPrev & ~sdaNow;
  wire stopSeen = sclNow & sclPrev & ~sdaPrev & sdaNow;
  wire wpFell = wpPrev & ~wpNow;
  wire [3:0] pinAddr = {addr_select_bit3, addr_select_bit2, addr_select_bit1, addr_select_bit0};

  // ==========================================================
  // Stored settings: index is pot*4 + register select
  reg [7:0] storedSetting [0:15];
  reg [7:0] wiperReg [0:3];

  // Select a stored slot from the instruction byte
  function [3:0] slotOf;
    input [7:0] instr;
    begin
      slotOf = {instr[1:0], instr[3:2]};
    end
  endfunction

  // ==========================================================
  // Transaction state
  reg [2:0] state;
  reg [1:0] bytePos;
  reg [3:0] bitCount;
  reg [7:0] shiftReg;
  reg [7:0] instrByte;
  reg [7:0] dataByte;
  reg isRead;
  reg ackThis;
  reg nvPending;
  reg wpAborted;
  reg [22:0] progCount;
  reg [7:0] settleCount;
  reg [4:0] loadIdx;
  integer i;

  wire [3:0] opcode = instrByte[7:4];
  wire [7:0] readValue = (opcode == `OPC_RD_STORED) ? storedSetting[slotOf(instrByte)] :
                         wiperReg[instrByte[1:0]];

  // Main bus state machine and program timer
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_LOAD;
      bytePos <= BY_ADDR;
      bitCount <= 4'h0;
      shiftReg <= 8'h00;
      instrByte <= 8'h00;
      dataByte <= 8'h00;
      isRead <= 1'b0;
      ackThis <= 1'b0;
      nvPending <= 1'b0;
      wpAborted <= 1'b0;
      progCount <= 23'h000000;
      loadIdx <= 5'h00;
      sdaOut <= 1'b1;
      sdaOe <= 1'b0;
      programBusy <= 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        storedSetting[i] <= `WIPER_RESET;
      end
      for (i = 0; i < 4; i = i + 1) begin
        wiperReg[i] <= `WIPER_RESET;
      end
    end else begin
      // Program cycle runs to its end regardless of protect
      if (programBusy) begin
        if (progCount == 23'h000000) begin
          programBusy <= 1'b0;
        end else begin
          progCount <= progCount - 23'h000001;
        end
      end
      // Protect falling after start, before the stop cycle, cancels the pending program
      if (wpFell && state != ST_IDLE) begin
        wpAborted <= 1'b1;
      end
      if (state == ST_LOAD) begin
        // Power-up recall of the first stored setting of each pot
        wiperReg[loadIdx[1:0]] <= storedSetting[{loadIdx[1:0], 2'h0}];
        loadIdx <= loadIdx + 5'h01;
        if (loadIdx == 5'h03) begin
          state <= ST_IDLE;
        end
      end else if (stopSeen) begin
        sdaOe <= 1'b0;
        if (nvPending && !wpAborted && !programBusy) begin
          storedSetting[slotOf(instrByte)] <= dataByte;
          programBusy <= 1'b1;
          progCount <= PROGRAM_CYCLES[22:0] - 23'h000001;
        end
        nvPending <= 1'b0;
        state <= ST_IDLE;
      end else if (startSeen) begin
        // Start, or repeated start, restarts address reception
        sdaOe <= 1'b0;
        state <= ST_RECV;
        bytePos <= BY_ADDR;
        bitCount <= 4'h0;
        nvPending <= 1'b0;
        // A protect fall seen in the start cycle still cancels; set wins over clear
        wpAborted <= wpFell;
      end else begin
        case (state)
          ST_IDLE: begin
            sdaOe <= 1'b0;
          end
          ST_RECV: begin
            if (sclRise) begin
              shiftReg <= {shiftReg[6:0], sdaNow};
              bitCount <= bitCount + 4'h1;
            end else if (sclFall && bitCount == 4'h8) begin
              bitCount <= 4'h0;
              ackThis <= 1'b0;
              case (bytePos)
                BY_ADDR: begin
                  // Busy programming: address is not answered
                  if (shiftReg[7:4] == `DEV_TYPE_CODE && shiftReg[3:0] == pinAddr[3:0] && !programBusy) begin
                    ackThis <= 1'b1;
                    sdaOe <= 1'b1;
                    sdaOut <= 1'b0;
                    state <= ST_ACK;
                  end else begin
                    state <= ST_IDLE;
                  end
                end
                BY_INSTR: begin
                  instrByte <= shiftReg;
                  isRead <= (shiftReg[7:4] == `OPC_RD_WIPER) || (shiftReg[7:4] == `OPC_RD_STORED);
                  ackThis <= 1'b1;
                  sdaOe <= 1'b1;
                  sdaOut <= 1'b0;
                  state <= ST_ACK;
                end
                default: begin
                  dataByte <= shiftReg;
                  if (opcode == `OPC_WR_STORED) begin
                    // Protected stored registers withhold the data ack
                    if (wpNow && !wpAborted) begin
                      nvPending <= 1'b1;
                      ackThis <= 1'b1;
                      sdaOe <= 1'b1;
                      sdaOut <= 1'b0;
                      state <= ST_ACK;
                    end else begin
                      state <= ST_WAIT;
                    end
                  end else begin
                    if (opcode == `OPC_WR_WIPER) begin
                      wiperReg[instrByte[1:0]] <= shiftReg;
                    end
                    ackThis <= 1'b1;
                    sdaOe <= 1'b1;
                    sdaOut <= 1'b0;
                    state <= ST_ACK;
                  end
                end
              endcase
            end
          end
          ST_ACK: begin
            // Release at the end of the ninth clock
            if (sclFall) begin
              sdaOe <= 1'b0;
              if (bytePos == BY_ADDR) begin
                bytePos <= BY_INSTR;
                state <= ST_RECV;
              end else if (bytePos == BY_INSTR && isRead) begin
                bytePos <= BY_DATA;
                shiftReg <= {readValue[6:0], 1'b0};
                sdaOe <= ~readValue[7];
                sdaOut <= 1'b0;
                bitCount <= 4'h1;
                state <= ST_SEND;
              end else if (bytePos == BY_INSTR) begin
                bytePos <= BY_DATA;
                state <= ST_RECV;
              end else begin
                state <= ST_WAIT;
              end
            end
          end
          ST_SEND: begin
            // Open-drain: enable only to drive a zero
            if (sclFall) begin
              if (bitCount == 4'h8) begin
                sdaOe <= 1'b0;
                state <= ST_MACK;
              end else begin
                sdaOe <= ~shiftReg[7];
                shiftReg <= {shiftReg[6:0], 1'b0};
                bitCount <= bitCount + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (sclRise) begin
              if (!sdaNow) begin
                shiftReg <= readValue;
                bitCount <= 4'h0;
                state <= ST_ACK;
                ackThis <= 1'b0;
                bytePos <= BY_INSTR;
              end else begin
                state <= ST_WAIT;
              end
            end
          end
          ST_WAIT: begin
            sdaOe <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Wiper outputs follow the registers after the settle time
  reg [31:0] wiperLatest;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wiperLatest <= 32'h00000000;
      wiperSettings <= 32'h00000000;
      wiperSettled <= 1'b0;
      settleCount <= 8'h00;
    end else begin
      wiperLatest <= {wiperReg[3], wiperReg[2], wiperReg[1], wiperReg[0]};
      if (wiperLatest != {wiperReg[3], wiperReg[2], wiperReg[1], wiperReg[0]}) begin
        settleCount <= SETTLE_CYCLES[7:0];
        wiperSettled <= 1'b0;
      end else if (settleCount != 8'h00) begin
        settleCount <= settleCount - 8'h01;
      end else if (state != ST_LOAD) begin
        wiperSettings <= wiperLatest;
        wiperSettled <= 1'b1;
      end
    end
  end

endmodule // pot_serial_slave_interface

// ==== include/pot_serial_map.vh ====
// Purpose: Constants for the two-wire potentiometer slave interface
// Assumes: core_clk at 40 MHz
// Notes: Times in their own unit, cycle counts derived from the clock rate
`ifndef POT_SERIAL_MAP_VH
`define POT_SERIAL_MAP_VH
`define CLK_FREQ_HZ 40000000
`define NV_PROGRAM_TIME_US 5000
`define NV_PROGRAM_CYCLES ((`NV_PROGRAM_TIME_US * (`CLK_FREQ_HZ / 1000000)))
`define WIPER_SETTLE_MIN_US 5
`define WIPER_SETTLE_CYCLES ((`WIPER_SETTLE_MIN_US * (`CLK_FREQ_HZ / 1000000)))
// Device-type code; the value is arbitrary
`define DEV_TYPE_CODE 4'hA
`define DEV_TYPE_MSB 7
`define DEV_TYPE_LSB 4
`define OPC_RD_WIPER 4'h9
`define OPC_WR_WIPER 4'hA
`define OPC_RD_STORED 4'hB
`define OPC_WR_STORED 4'hC
`define WIPER_RESET 8'h00
`endif

// ==== tb/pot_serial_monitor.sv ====
// Purpose: Bus and timing checker for the pot serial slave
// Assumes: One core_clk domain, pins sampled raw
// Notes: Bound to the slave's top ports
`timescale 1ns/10ps
module pot_serial_monitor #(
  parameter PROGRAM_CYCLES = 300,
  parameter SETTLE_CYCLES = 4
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Bus pins
  input wire scl,
  input wire sdaIn,
  input wire sdaOut,
  input wire sdaOe,
  // Status
  input wire wiperSettled,
  input wire programBusy
);
  default clocking mainClk @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========
  // Helper state
  reg sdaPast;
  reg inFrame;
  reg [7:0] stopAge;
  reg [19:0] busyCnt;
  reg [19:0] unsetCnt;
  wire startEv = scl && sdaPast && !sdaIn;
  wire stopEv = scl && !sdaPast && sdaIn;
  // Frame flag and counters; stopAge saturates so long idles never wrap
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sdaPast <= 1'b1;
      inFrame <= 1'b0;
      stopAge <= 8'hFF;
      busyCnt <= 20'h0;
      unsetCnt <= 20'h0;
    end else begin
      sdaPast <= sdaIn;
      inFrame <= startEv | (inFrame & ~stopEv);
      stopAge <= stopEv ? 8'h0 : stopAge + {7'h0, stopAge != 8'hFF};
      busyCnt <= programBusy ? busyCnt + 20'h1 : 20'h0;
      unsetCnt <= wiperSettled ? 20'h0 : unsetCnt + 20'h1;
    end
  end
  sequence stopSeq;
    stopEv;
  endsequence
  sequence quiet8;
    !sdaOe [*8];
  endsequence
  // ==========
  // Assertions
  chk_drive_low: assert property (sdaOe |-> !sdaOut) else $error("pin driven high");
  chk_oe_scl_low: assert property ($changed(sdaOe) |-> !scl) else $error("drive moved, clock high");
  chk_idle_quiet: assert property (!inFrame |-> !sdaOe) else $error("drive outside frame");
  chk_stop_idle: assert property (stopSeq |=> quiet8) else $error("drive after stop");
  chk_busy_quiet: assert property (programBusy |-> !sdaOe) else $error("drive while busy");
  chk_busy_bound: assert property (programBusy |-> busyCnt < PROGRAM_CYCLES) else $error("busy too long");
  chk_busy_cause: assert property ($rose(programBusy) |-> stopAge < 8) else $error("busy without stop");
  chk_settle_max: assert property (!wiperSettled |-> unsetCnt < 2 * SETTLE_CYCLES + 8) else $error("slow wiper");
endmodule // pot_serial_monitor

bind pot_serial_slave_interface pot_serial_monitor #(
  .PROGRAM_CYCLES(PROGRAM_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)
) u_mon (.core_clk(core_clk), .rst(rst), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .wiperSettled(wiperSettled), .programBusy(programBusy));

// ==== tb/pot_bus_master.sv ====
// Purpose: Two-wire bus master model
// Assumes: 200 ns bit clock, 6 cycles low and 2 high
// Notes: Data bits change only mid-low; clock idles high
`timescale 1ns/10ps
module pot_bus_master (
  // Clock
  input wire core_clk,
  // Bus
  input wire sda,
  output reg scl,
  output reg sdaDrv
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic tick(input integer n);
    repeat (n) @(negedge core_clk);
  endtask
  // Start only from an idle bus
  task automatic start;
    sdaDrv = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask
  // Every operation closes with stop, then a free-bus gap
  task automatic stop;
    tick(2);
    sdaDrv = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sdaDrv = 1'b1;
    tick(6);
  endtask
  // One clock: data set while low, sampled at end of high
  task automatic bitx(input logic b, output logic r);
    tick(2);
    sdaDrv = b;
    tick(4);
    scl = 1'b1;
    tick(2);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic recvByte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(!ack, r);
  endtask
endmodule // pot_bus_master

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the pot serial slave
// Assumes: Short program and settle counts
// Notes: Bus driven by the master model
`timescale 1ns/10ps
`include "pot_serial_map.vh"
module tb;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] pins = 4'h6;
  reg writeProtect_n = 1'b1;
  wire scl, sdaDrv, sdaOut, sdaOe, wiperSettled, programBusy;
  wire [31:0] wiperSettings;
  wire [7:0] devAddr = {`DEV_TYPE_CODE, pins};
  // Open-drain wire with pull-up
  wire sda = sdaDrv & ~(sdaOe & ~sdaOut);
  integer bad_count = 0;
  integer n_tests = 0;
  logic a0, a1, a2;
  logic [2:0] ak;
  always #12.5 core_clk = ~core_clk;
  pot_serial_slave_interface #(.PROGRAM_CYCLES(300), .SETTLE_CYCLES(4)) u_dut (.core_clk(core_clk), .rst(rst),
    .scl(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_select_bit0(pins[0]), .addr_select_bit1(pins[1]),
    .addr_select_bit2(pins[2]), .addr_select_bit3(pins[3]), .writeProtect_n(writeProtect_n),
    .wiperSettings(wiperSettings), .wiperSettled(wiperSettled), .programBusy(programBusy));
  pot_bus_master u_mst (.core_clk(core_clk), .sda(sda), .scl(scl), .sdaDrv(sdaDrv));
  // ==========
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Bounded wait for programming and settling to finish
  task automatic waitIdle;
    for (int i = 0; i < 400 && (programBusy !== 1'b0 || wiperSettled !== 1'b1); i++) @(negedge core_clk);
    check({programBusy, wiperSettled}, 2'h1);
  endtask
  task automatic poll(output logic ack);
    u_mst.start();
    u_mst.sendByte(devAddr, ack);
    u_mst.stop();
  endtask
  task automatic wr3(input logic [7:0] ins, input logic [7:0] d);
    u_mst.start();
    u_mst.sendByte(devAddr, ak[2]);
    u_mst.sendByte(ins, ak[1]);
    u_mst.sendByte(d, ak[0]);
    u_mst.stop();
  endtask
  // Read twice: master ack repeats the value, nack ends it
  task automatic rdchk(input logic [7:0] ins, input logic [7:0] exp);
    logic [7:0] d;
    logic x;
    u_mst.start();
    u_mst.sendByte(devAddr, x);
    u_mst.sendByte(ins, x);
    u_mst.recvByte(1'b1, d);
    check(d, exp);
    u_mst.recvByte(1'b0, d);
    check(d, exp);
    u_mst.stop();
  endtask
  // ==========
  // Scenarios
  task automatic t_power;
    waitIdle();
    check(wiperSettings, 32'h0);
    u_mst.sendByte(devAddr, a0);
    u_mst.stop();
    check(a0, 1'b0);
    $display("power-up test done");
  endtask
  // Wrong type code, each pin flipped, then the match
  task automatic t_addr;
    for (int i = 0; i < 6; i++) begin
      u_mst.start();
      u_mst.sendByte({(i == 0) ? ~`DEV_TYPE_CODE : `DEV_TYPE_CODE,
        (i > 0 && i < 5) ? pins ^ (4'h1 << (i - 1)) : pins}, a0);
      u_mst.sendByte(devAddr, a1);
      u_mst.stop();
      check({a0, a1}, (i == 5) ? 2'h3 : 2'h0);
    end
    $display("address test done");
  endtask
  task automatic t_wiper;
    wr3({`OPC_WR_WIPER, 4'h2}, 8'h5A);
    check(ak, 3'h7);
    waitIdle();
    check(wiperSettings, 32'h005A0000);
    rdchk({`OPC_RD_WIPER, 4'h2}, 8'h5A);
    $display("wiper test done");
  endtask
  task automatic t_stored;
    wr3({`OPC_WR_STORED, 4'hD}, 8'h3C);
    check({ak, programBusy}, 4'hF);
    poll(a0);
    check(a0, 1'b0);
    waitIdle();
    poll(a0);
    check(a0, 1'b1);
    rdchk({`OPC_RD_STORED, 4'hD}, 8'h3C);
    check(wiperSettings, 32'h005A0000);
    $display("stored test done");
  endtask
  task automatic t_protect;
    writeProtect_n = 1'b0;
    wr3({`OPC_WR_STORED, 4'hD}, 8'h77);
    check({ak, programBusy}, 4'hC);
    writeProtect_n = 1'b1;
    rdchk({`OPC_RD_STORED, 4'hD}, 8'h3C);
    u_mst.start();
    u_mst.sendByte(devAddr, a0);
    // Protect pulses low mid-frame and is high again by the data byte
    writeProtect_n = 1'b0;
    u_mst.sendByte({`OPC_WR_STORED, 4'hD}, a1);
    writeProtect_n = 1'b1;
    u_mst.sendByte(8'h11, a2);
    u_mst.stop();
    check({a0, a1, a2, programBusy}, 4'hC);
    wr3({`OPC_WR_STORED, 4'hD}, 8'h99);
    check({ak, programBusy}, 4'hF);
    writeProtect_n = 1'b0;
    waitIdle();
    writeProtect_n = 1'b1;
    rdchk({`OPC_RD_STORED, 4'hD}, 8'h99);
    $display("protect test done");
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    repeat (12) @(negedge core_clk);
    t_power();
    t_addr();
    t_wiper();
    t_stored();
    t_protect();
    end_sim();
  end
  // Watchdog, well beyond the expected run
  initial begin
    #1000000;
    bad_count++;
    end_sim();
  end
endmodule // tb
